/* File: logic/dswp_pkg.sv */
// Package with constants for the drive status word profile block.
package dswp_pkg;
  // Status word bit positions.
  localparam int unsigned SW_CTRL_READY = 0;
  localparam int unsigned SW_DRIVE_READY = 1;
  localparam int unsigned SW_ENABLE = 2;
  localparam int unsigned SW_TRIP = 3;
  localparam int unsigned SW_ERROR = 4;
  localparam int unsigned SW_UNUSED = 5;
  localparam int unsigned SW_TRIPLOCK = 6;
  localparam int unsigned SW_WARNING = 7;
  localparam int unsigned SW_AT_REF = 8;
  localparam int unsigned SW_BUS_CTRL = 9;
  localparam int unsigned SW_FREQ_OK = 10;
  localparam int unsigned SW_RUNNING = 11;
  localparam int unsigned SW_OVERTEMP = 12;
  localparam int unsigned SW_VOLTAGE = 13;
  localparam int unsigned SW_TORQUE = 14;
  localparam int unsigned SW_TIMER = 15;
  // Control word bit positions.
  localparam int unsigned CW_RESET = 7;
  localparam int unsigned CW_VALID = 10;
  localparam int unsigned CW_REVERSE = 15;
  // Values after reset.
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic SW_UNUSED_VALUE = 1'h0;
  // Relative scaling: this code means 100 percent.
  localparam logic [15:0] FULL_SCALE = 16'h4000;
  // Thermal timer level meaning 100 percent.
  localparam logic [15:0] TIMER_FULL = 16'h4000;
  // Reversing source selection codes.
  typedef enum logic [1:0] {
    DSWP_REV_DIGITAL = 2'h0,
    DSWP_REV_SERIAL = 2'h1,
    DSWP_REV_OR = 2'h2,
    DSWP_REV_AND = 2'h3
  } dswp_rev_src_t;
endpackage

/* File: logic/dswp_trip_ctrl.sv */
// Trip and trip-lock keeper with one combined reset request input.
`timescale 1ns/100ps
module dswp_trip_ctrl
  import dswp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_alarm,
  input wire logic i_lock_alarm,
  input wire logic i_power_cycled,
  input wire logic i_reset_req,
  output logic o_trip,
  output logic o_triplock
);
  logic trip_q, trip_d, lock_q, lock_d;

  // A trip holds after its cause leaves; reset only clears a cause-free
  // trip, so a standing alarm wins over a reset in the same cycle.
  always_comb begin
    trip_d = trip_q;
    lock_d = lock_q;
    if (i_power_cycled) begin
      lock_d = 1'b0;
    end
    if (i_reset_req && !lock_q && !i_alarm && !i_lock_alarm) begin
      trip_d = 1'b0;
    end
    if (i_alarm || i_lock_alarm) begin
      trip_d = 1'b1;
    end
    if (i_lock_alarm) begin
      lock_d = 1'b1;
    end
  end

  // Registers the trip state.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      trip_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      trip_q <= trip_d;
      lock_q <= lock_d;
    end
  end

  assign o_trip = trip_q;
  assign o_triplock = lock_q;
endmodule

/* File: logic/dswp_ref_scale.sv */
// Saturating scaler of relative signed values onto the 16384 full scale.
`timescale 1ns/100ps
module dswp_ref_scale
  import dswp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic signed [15:0] i_value,
  input wire logic signed [15:0] i_full,
  output logic signed [15:0] o_scaled
);
  logic signed [15:0] scaled_q, scaled_d;
  logic signed [31:0] prod;
  logic signed [31:0] quot;

  // Value times 16384 over the internal full scale, clamped to 16 bits.
  always_comb begin
    prod = 32'(i_value) * 32'(signed'({16'h0000, FULL_SCALE}));
    quot = (i_full == 16'sh0000) ? 32'sh0 : prod / 32'(i_full);
    if (quot > 32'sh00007fff) begin
      scaled_d = 16'sh7fff;
    end else if (quot < -32'sh00008000) begin
      scaled_d = -16'sh8000;
    end else begin
      scaled_d = quot[15:0];
    end
  end

  // Registers the result so the output comes from a flip-flop.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scaled_q <= 16'sh0000;
    end else begin
      scaled_q <= scaled_d;
    end
  end

  assign o_scaled = scaled_q;
endmodule

/* File: logic/dswp_top.sv */
// Serial-bus profile logic: status word, control word and scaled values.
// What this block does
// - Control bit 15 reverses only with serial, OR or AND source.
// - Status bit 0 is one when controls ready, zero when tripped.
// - Status bit 1 is one when ready but coast still commanded.
// - Status bit 2 is zero while coasting, one when start enabled.
// - Status bit 3 shows a trip and holds until reset.
// - Status bit 4 shows an error that does not trip.
// - Status bit 5 is unused and constant.
// - Status bit 6 shows a trip lock needing power cycle.
// - Status bit 7 shows any present warning.
// - Status bit 8 shows motor speed equals reference.
// - Status bit 9 shows bus control possible, not local.
// - Status bit 10 shows frequency inside low and high limits.
// - Status bit 11 shows start signal or frequency other than zero.
// - Status bit 12 shows temporary over-temperature halt, self clearing.
// - Status bit 13 shows DC voltage too low or high.
// - Status bit 14 shows current above the torque limit.
// - Status bit 15 shows a thermal timer above full level.
// - Whole status word reads zero on link or internal fault.
// - Reference and frequency are 16-bit, 16384 means full scale.
// - Warnings follow their cause and clear without reset.
// - Alarms trip; trip holds until reset after cause removed.
// - Trip reset from panel, input, bus or automatic reset.
// - Bus reset acts on rising edge of control bit 7.
// - Control word is ignored when its valid bit 10 is zero.
`timescale 1ns/100ps
module dswp_top
  import dswp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_ctrl_word,
  input wire logic i_ctrl_strobe,
  input wire logic [1:0] i_rev_src,
  input wire logic i_dig_reverse,
  input wire logic i_controls_ready,
  input wire logic i_drive_ready,
  input wire logic i_coast_active,
  input wire logic i_alarm,
  input wire logic i_lock_alarm,
  input wire logic i_power_cycled,
  input wire logic i_error_no_trip,
  input wire logic i_warning,
  input wire logic i_local_operator_panel_stop,
  input wire logic i_local_ref_selected,
  input wire logic i_start_signal,
  input wire logic i_overtemp_halt,
  input wire logic i_dc_low,
  input wire logic i_dc_high,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_current_limit,
  input wire logic [15:0] i_motor_timer,
  input wire logic [15:0] i_inverter_timer,
  input wire logic signed [15:0] i_out_freq,
  input wire logic signed [15:0] i_speed_ref,
  input wire logic signed [15:0] i_freq_low_limit,
  input wire logic signed [15:0] i_freq_high_limit,
  input wire logic signed [15:0] i_freq_full,
  input wire logic i_link_lost,
  input wire logic i_internal_comm_fault,
  input wire logic i_panel_reset,
  input wire logic i_dig_reset,
  input wire logic i_auto_reset,
  output logic [15:0] o_drive_status_word,
  output logic [15:0] o_ctrl_word,
  output logic o_reverse,
  output logic signed [15:0] o_actual_output_frequency_value,
  output logic signed [15:0] o_speed_ref_value
);
  logic [15:0] status_q, status_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic rst_bit_q, rst_bit_d;
  logic rev_q, rev_d;
  logic bus_reset;
  logic reset_req;
  logic trip, triplock;
  logic [15:0] abs_freq;

  // Bus reset is the rising edge of the reset bit of an accepted word.
  assign bus_reset = i_ctrl_strobe && i_ctrl_word[CW_VALID] &&
                     i_ctrl_word[CW_RESET] && !rst_bit_q;
  // Any of the four reset sources can clear a trip.
  assign reset_req = i_panel_reset || i_dig_reset || bus_reset ||
                     i_auto_reset;

  // Trip memory lives in its own module so it can be reused per profile.
  dswp_trip_ctrl u_trip (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_alarm(i_alarm),
    .i_lock_alarm(i_lock_alarm),
    .i_power_cycled(i_power_cycled),
    .i_reset_req(reset_req),
    .o_trip(trip),
    .o_triplock(triplock)
  );

  // Actual output frequency scaled onto the relative bus format.
  dswp_ref_scale u_freq_scale (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_value(i_out_freq),
    .i_full(i_freq_full),
    .o_scaled(o_actual_output_frequency_value)
  );

  // Speed reference scaled the same way, so the two compare directly.
  dswp_ref_scale u_ref_scale (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_value(i_speed_ref),
    .i_full(i_freq_full),
    .o_scaled(o_speed_ref_value)
  );

  // Control word latch; invalid words leave every held bit untouched.
  always_comb begin
    ctrl_d = ctrl_q;
    rst_bit_d = rst_bit_q;
    if (i_ctrl_strobe && i_ctrl_word[CW_VALID]) begin
      ctrl_d = i_ctrl_word;
      rst_bit_d = i_ctrl_word[CW_RESET];
    end
  end

  // Reverse request depends on the chosen source; AND needs both.
  always_comb begin
    case (dswp_rev_src_t'(i_rev_src))
      DSWP_REV_DIGITAL: rev_d = i_dig_reverse;
      DSWP_REV_SERIAL: rev_d = ctrl_d[CW_REVERSE];
      DSWP_REV_OR: rev_d = ctrl_d[CW_REVERSE] || i_dig_reverse;
      DSWP_REV_AND: rev_d = ctrl_d[CW_REVERSE] && i_dig_reverse;
      default: rev_d = i_dig_reverse;
    endcase
  end

  // Absolute output frequency for the running test.
  assign abs_freq = i_out_freq[15] ? 16'(-i_out_freq) : i_out_freq;

  // Assembles the status word from live conditions each clock; warnings
  // are not latched so they drop as soon as their cause goes.
  always_comb begin
    status_d = STATUS_RESET;
    status_d[SW_CTRL_READY] = i_controls_ready && !trip;
    status_d[SW_DRIVE_READY] = i_drive_ready && i_coast_active;
    status_d[SW_ENABLE] = !i_coast_active && !trip;
    status_d[SW_TRIP] = trip;
    status_d[SW_ERROR] = i_error_no_trip;
    status_d[SW_UNUSED] = SW_UNUSED_VALUE;
    status_d[SW_TRIPLOCK] = triplock;
    status_d[SW_WARNING] = i_warning;
    status_d[SW_AT_REF] = (i_out_freq == i_speed_ref);
    status_d[SW_BUS_CTRL] = !i_local_operator_panel_stop &&
                            !i_local_ref_selected;
    status_d[SW_FREQ_OK] = (i_out_freq > i_freq_low_limit) &&
                           (i_out_freq < i_freq_high_limit);
    status_d[SW_RUNNING] = i_start_signal ||
                           (abs_freq != 16'h0000);
    status_d[SW_OVERTEMP] = i_overtemp_halt;
    status_d[SW_VOLTAGE] = i_dc_low || i_dc_high;
    status_d[SW_TORQUE] = i_motor_current > i_current_limit;
    status_d[SW_TIMER] = (i_motor_timer > TIMER_FULL) ||
                         (i_inverter_timer > TIMER_FULL);
    if (i_link_lost || i_internal_comm_fault) begin
      status_d = 16'h0000;
    end
  end

  // Registers status, control word, reset bit and reverse; the status word is one coherent snapshot.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      status_q <= STATUS_RESET;
      ctrl_q <= CTRL_RESET;
      rst_bit_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      status_q <= status_d;
      ctrl_q <= ctrl_d;
      rst_bit_q <= rst_bit_d;
      rev_q <= rev_d;
    end
  end

  assign o_drive_status_word = status_q;
  assign o_ctrl_word = ctrl_q;
  assign o_reverse = rev_q;
endmodule

/* File: verification/dswp_checker.sv */
// Assertion checker bound to the drive status word profile top.
`timescale 1ns/100ps
module dswp_checker
  import dswp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_ctrl_word,
  input wire logic i_ctrl_strobe,
  input wire logic [1:0] i_rev_src,
  input wire logic i_warning,
  input wire logic i_dc_low,
  input wire logic i_dc_high,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_current_limit,
  input wire logic [15:0] i_motor_timer,
  input wire logic [15:0] i_inverter_timer,
  input wire logic i_link_lost,
  input wire logic i_internal_comm_fault,
  input wire logic i_panel_reset,
  input wire logic i_dig_reset,
  input wire logic i_auto_reset,
  input wire logic [15:0] o_drive_status_word,
  input wire logic [15:0] o_ctrl_word,
  input wire logic o_reverse
);
  logic flt;
  logic rq;
  // Any strobe counts as a possible reset, so the hold check stays safe.
  assign flt = i_link_lost | i_internal_comm_fault;
  assign rq = i_panel_reset | i_dig_reset | i_auto_reset | i_ctrl_strobe;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // A cycle with no request, then the trip bit seen set.
  sequence s_quiet_trip;
    !rq ##1 (o_drive_status_word[SW_TRIP] && !flt);
  endsequence
  a_fault_zero: assert property (
    flt |=> o_drive_status_word == 16'h0000) else $error("fault not zero");
  a_warn_follow: assert property (
    !flt |=> o_drive_status_word[SW_WARNING] == $past(i_warning))
    else $error("warning bit wrong");
  a_unused_const: assert property (
    o_drive_status_word[SW_UNUSED] == SW_UNUSED_VALUE)
    else $error("unused bit moved");
  a_volt_bit: assert property (
    !flt |=> o_drive_status_word[SW_VOLTAGE] == $past(i_dc_low | i_dc_high))
    else $error("voltage bit wrong");
  a_torque_bit: assert property (
    !flt |=> o_drive_status_word[SW_TORQUE] ==
    $past(i_motor_current > i_current_limit)) else $error("torque bit");
  a_timer_bit: assert property (
    !flt |=> o_drive_status_word[SW_TIMER] == $past(i_motor_timer >
    TIMER_FULL || i_inverter_timer > TIMER_FULL)) else $error("timer bit");
  a_rev_serial: assert property (
    i_ctrl_strobe && i_ctrl_word[CW_VALID] && i_rev_src == DSWP_REV_SERIAL
    |=> o_reverse == $past(i_ctrl_word[CW_REVERSE])) else $error("reverse");
  a_invalid_ignored: assert property (
    i_ctrl_strobe && !i_ctrl_word[CW_VALID] |=> $stable(o_ctrl_word))
    else $error("invalid word taken");
  a_trip_hold: assert property (
    s_quiet_trip |=> o_drive_status_word[SW_TRIP]) else $error("trip lost");
endmodule
bind dswp_top dswp_checker i_chk (.*);

/* File: verification/dswp_master_model.sv */
// Behavioural serial master that sends control words to the block.
`timescale 1ns/100ps
module dswp_master_model (
  input wire logic i_clk,
  output logic [15:0] o_word,
  output logic o_strobe
);
  // Bus starts idle with no word present.
  initial begin
    o_word = 16'h0000;
    o_strobe = 1'b0;
  end
  // One word per strobe; the idle word is inverted so stale data never
  // looks like the last frame.
  task automatic send(input logic [15:0] w);
    @(posedge i_clk);
    #1;
    o_word = w;
    o_strobe = 1'b1;
    @(posedge i_clk);
    #1;
    o_strobe = 1'b0;
    o_word = ~w;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the drive status word profile block.
`timescale 1ns/100ps
module tb_top;
  logic i_clk, i_rstn, i_ctrl_strobe, i_dig_reverse, i_controls_ready;
  logic i_drive_ready, i_coast_active, i_alarm, i_lock_alarm, i_warning;
  logic i_power_cycled, i_error_no_trip, i_start_signal, i_overtemp_halt;
  logic i_local_operator_panel_stop, i_local_ref_selected, i_dc_low;
  logic i_dc_high, i_link_lost, i_internal_comm_fault, i_panel_reset;
  logic i_dig_reset, i_auto_reset, o_reverse;
  logic [1:0] i_rev_src;
  logic [15:0] i_ctrl_word, i_motor_current, i_current_limit;
  logic [15:0] i_motor_timer, i_inverter_timer, o_drive_status_word;
  logic [15:0] o_ctrl_word;
  logic signed [15:0] i_out_freq, i_speed_ref, i_freq_low_limit;
  logic signed [15:0] i_freq_high_limit, i_freq_full, o_speed_ref_value;
  logic signed [15:0] o_actual_output_frequency_value;
  int err_count, total_checks;
  dswp_top i_dut (.*);
  dswp_master_model i_mst (.i_clk(i_clk), .o_word(i_ctrl_word),
    .o_strobe(i_ctrl_strobe));
  // Free-running 25 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Status settles in one edge and trip bits in two; three leaves a spare edge.
  task automatic sw(input logic [15:0] e);
    tick(3);
    chk("status", o_drive_status_word, e);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic trip;
    pulse(i_alarm);
    sw(16'h0708);
  endtask
  task close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Guards against a hang anywhere in the sequence.
  initial begin
    #400000;
    err_count++;
    close_out;
  end
  // Main sequence: status bits, trips, control words, scaling.
  initial begin
    {i_rstn, i_dig_reverse, i_drive_ready, i_coast_active, i_alarm} = '0;
    {i_lock_alarm, i_warning, i_power_cycled, i_error_no_trip} = '0;
    {i_start_signal, i_overtemp_halt, i_local_operator_panel_stop} = '0;
    {i_local_ref_selected, i_dc_low, i_dc_high, i_link_lost} = '0;
    {i_internal_comm_fault, i_panel_reset, i_dig_reset, i_auto_reset} = '0;
    {i_rev_src, i_motor_current, i_current_limit, i_motor_timer} = '0;
    {i_inverter_timer, i_out_freq, i_speed_ref} = '0;
    i_controls_ready = 1'b1;
    i_freq_low_limit = -16'sd100;
    i_freq_high_limit = 16'sd100;
    i_freq_full = 16'sd1000;
    tick(4);
    chk("reset", o_drive_status_word, 16'h0000);
    tick(1);
    i_rstn = 1'b1;
    sw(16'h0705);
    i_warning = 1'b1;
    sw(16'h0785);
    i_warning = 1'b0;
    i_dc_high = 1'b1;
    sw(16'h2705);
    i_dc_high = 1'b0;
    i_dc_low = 1'b1;
    sw(16'h2705);
    i_dc_low = 1'b0;
    i_controls_ready = 1'b0;
    sw(16'h0704);
    i_controls_ready = 1'b1;
    i_motor_current = 16'h000a;
    i_current_limit = 16'h0005;
    sw(16'h4705);
    i_motor_current = 16'h0000;
    i_motor_timer = 16'h4000;
    sw(16'h0705);
    i_inverter_timer = 16'h4001;
    sw(16'h8705);
    {i_motor_timer, i_inverter_timer} = '0;
    i_error_no_trip = 1'b1;
    sw(16'h0715);
    i_error_no_trip = 1'b0;
    i_overtemp_halt = 1'b1;
    sw(16'h1705);
    i_overtemp_halt = 1'b0;
    {i_drive_ready, i_coast_active} = 2'h3;
    sw(16'h0703);
    {i_drive_ready, i_coast_active, i_start_signal} = 3'h1;
    sw(16'h0f05);
    {i_start_signal, i_local_operator_panel_stop} = 2'h1;
    sw(16'h0505);
    {i_local_operator_panel_stop, i_local_ref_selected} = 2'h1;
    sw(16'h0505);
    i_local_ref_selected = 1'b0;
    i_out_freq = 16'sd100;
    sw(16'h0a05);
    i_freq_high_limit = 16'sd200;
    sw(16'h0e05);
    i_freq_low_limit = 16'sd100;
    sw(16'h0a05);
    i_freq_low_limit = -16'sd100;
    i_freq_high_limit = 16'sd100;
    i_out_freq = 16'sd0;
    i_link_lost = 1'b1;
    sw(16'h0000);
    {i_link_lost, i_internal_comm_fault} = 2'h1;
    sw(16'h0000);
    i_internal_comm_fault = 1'b0;
    $display("status test done");
    trip;
    sw(16'h0708);
    i_alarm = 1'b1;
    pulse(i_panel_reset);
    sw(16'h0708);
    i_alarm = 1'b0;
    pulse(i_panel_reset);
    sw(16'h0705);
    trip;
    pulse(i_dig_reset);
    sw(16'h0705);
    trip;
    pulse(i_auto_reset);
    sw(16'h0705);
    trip;
    i_mst.send(16'h0480);
    sw(16'h0705);
    trip;
    i_mst.send(16'h0480);
    sw(16'h0708);
    i_mst.send(16'h0400);
    i_mst.send(16'h0480);
    sw(16'h0705);
    pulse(i_lock_alarm);
    sw(16'h0748);
    pulse(i_panel_reset);
    sw(16'h0748);
    pulse(i_power_cycled);
    pulse(i_panel_reset);
    sw(16'h0705);
    $display("trip test done");
    for (int s = 0; s < 4; s++) begin
      i_rev_src = s[1:0];
      i_dig_reverse = 1'b0;
      i_mst.send(16'h8400);
      tick(1);
      chk("reverse", {15'h0000, o_reverse},
          {15'h0000, s == 1 || s == 2});
      i_dig_reverse = 1'b1;
      i_mst.send(16'h0400);
      tick(1);
      chk("reverse", {15'h0000, o_reverse},
          {15'h0000, s == 0 || s == 2});
    end
    i_mst.send(16'h8000);
    tick(1);
    chk("ctrl", o_ctrl_word, 16'h0400);
    chk("reverse", {15'h0000, o_reverse}, 16'h0000);
    $display("control test done");
    i_out_freq = 16'sd500;
    i_speed_ref = -16'sd1000;
    tick(2);
    chk("freq", o_actual_output_frequency_value, 16'h2000);
    chk("ref", o_speed_ref_value, 16'hc000);
    i_out_freq = -16'sd500;
    i_speed_ref = 16'sd1000;
    tick(2);
    chk("freq", o_actual_output_frequency_value, 16'he000);
    chk("ref", o_speed_ref_value, 16'h4000);
    // A doubled internal full scale halves both relative values.
    i_freq_full = 16'sd2000;
    tick(2);
    chk("freq", o_actual_output_frequency_value, 16'hf000);
    chk("ref", o_speed_ref_value, 16'h2000);
    $display("scale test done");
    close_out;
  end
endmodule
